// ===== ssid_loader.sv
// Subsystem identifier loader: uploads four EEPROM bytes into the config word.
// Assumes the PCI target decodes config accesses and honours the retry output.
//
// Functional notes
// - Identifier word lives at config offset 0x20.
// - After reset seize I2C, read four bytes from 0xFC.
// - EEPROM answers at 1010000; control bytes A0/A1.
// - Start, A0, address, restart, A1, each acked.
// - Bytes fill subsystem ID high, low, vendor high, low.
// - Ack first three bytes, nack fourth, then stop.
// - Any slave nack aborts; word reads zero.
// - Whole upload takes about 660 microseconds.
// - Access before update is retried.
// - Writes ignored unless write enable is set.
// - Software programs EEPROM with start, A0, address, data, stop.
`timescale 1ns/1ps
`default_nettype none
module ssid_loader #(
	parameter int QUARTER = ssid_pkg::SSID_QUARTER_CYC
) (
	// Clock and reset.
	input  wire logic        mclk_i,
	input  wire logic        rst_i,
	// Configuration access to the identifier word.
	input  wire logic        cfg_rd_i,
	input  wire logic        cfg_wr_i,
	input  wire logic [7:0]  cfg_addr_i,
	input  wire logic [31:0] cfg_wdata_i,
	input  wire logic [3:0]  cfg_be_i,
	output logic [31:0]      cfg_rdata_o,
	output logic             cfg_hit_o,
	output logic             cfg_retry_o,
	// Write enable bit from the device control register.
	input  wire logic        subsys_id_write_enable_i,
	// I2C pins while the loader owns the master.
	input  wire logic        scl_i,
	output logic             scl_o,
	output logic             scl_oe_o,
	input  wire logic        sda_i,
	output logic             sda_o,
	output logic             sda_oe_o,
	// Ownership and status.
	output logic             i2c_owned_o,
	output logic             upload_ok_o
);
	import ssid_pkg::*;

	// ****************************************
	// Upload sequencer
	// ****************************************
	typedef enum logic [5:0] {
		SSID_ST_START  = 6'h01,
		SSID_ST_SEND   = 6'h02,
		SSID_ST_RESTART= 6'h04,
		SSID_ST_READ   = 6'h08,
		SSID_ST_STOP   = 6'h10,
		SSID_ST_IDLE   = 6'h20
	} ssid_state_t;

	ssid_bit_if  bus ();
	ssid_state_t state_reg;
	ssid_state_t state_next;
	logic [1:0]  idx_reg;
	logic [1:0]  idx_next;
	logic        req_reg;
	logic        abort_reg;
	logic        abort_next;
	logic        ok_reg;
	logic [31:0] word_reg;
	logic [31:0] shadow_reg;

	ssid_i2c_engine #(.QUARTER(QUARTER)) u_eng (
		.mclk_i   (mclk_i),
		.rst_i    (rst_i),
		.bus      (bus),
		.scl_i    (scl_i),
		.scl_o    (scl_o),
		.scl_oe_o (scl_oe_o),
		.sda_i    (sda_i),
		.sda_o    (sda_o),
		.sda_oe_o (sda_oe_o)
	);

	// The sequencer walks the upload one engine step at a time.
	// Each step is requested for a single cycle after the previous one is done.
	// A nack on any written byte skips straight to the stop step.
	// The read bytes are acked by the master except the last one.
	// The engine holds both lines between steps, so no glitch appears.
	// Ownership ends one edge after the stop step completes, on the edge that takes its done pulse.
	// Command presented to the engine for each state.
	wire idle = (state_reg == SSID_ST_IDLE);
	assign bus.req = req_reg;
	assign bus.master_ack = (idx_reg != 2'h3);
	always_comb begin
		case (state_reg)
			SSID_ST_START:   bus.cmd = SSID_CMD_START;
			SSID_ST_RESTART: bus.cmd = SSID_CMD_START;
			SSID_ST_SEND:    bus.cmd = SSID_CMD_WRITE;
			SSID_ST_READ:    bus.cmd = SSID_CMD_READ;
			default:         bus.cmd = SSID_CMD_STOP;
		endcase
	end
	// Byte sent in SEND: control byte then address; after restart, read control.
	assign bus.wdata = (idx_reg == 2'h0) ? SSID_CTRL_WRITE :
		(idx_reg == 2'h1) ? SSID_FIRST_ADDR : SSID_CTRL_READ;

	// Next state on each completed step; any slave nack goes to stop.
	always_comb begin
		state_next = state_reg;
		idx_next = idx_reg;
		abort_next = abort_reg;
		if (bus.done) begin
			case (state_reg)
				SSID_ST_START: begin
					state_next = SSID_ST_SEND;
					idx_next = 2'h0;
				end
				SSID_ST_SEND: begin
					if (!bus.slave_ack) begin
						state_next = SSID_ST_STOP;
						abort_next = 1'b1;
					end else if (idx_reg == 2'h0) begin
						idx_next = 2'h1;
					end else if (idx_reg == 2'h1) begin
						state_next = SSID_ST_RESTART;
						idx_next = 2'h2;
					end else begin
						state_next = SSID_ST_READ;
						idx_next = 2'h0;
					end
				end
				SSID_ST_RESTART: state_next = SSID_ST_SEND;
				SSID_ST_READ: begin
					idx_next = idx_reg + 2'h1;
					if (idx_reg == 2'h3)
						state_next = SSID_ST_STOP;
				end
				SSID_ST_STOP:    state_next = SSID_ST_IDLE;
				default:         state_next = SSID_ST_IDLE;
			endcase
		end
	end

	// Sequencer registers; the first request issues right after reset.
	always_ff @(posedge mclk_i) begin
		if (rst_i) begin
			state_reg <= SSID_ST_START;
			idx_reg <= 2'h0;
			abort_reg <= 1'b0;
			req_reg <= 1'b1;
		end else begin
			state_reg <= state_next;
			idx_reg <= idx_next;
			abort_reg <= abort_next;
			req_reg <= bus.done && (state_next != SSID_ST_IDLE);
		end
	end

	// ****************************************
	// Identifier word
	// ****************************************
	// A config write lands only when the loader is idle and the enable bit is set.
	// Writes during the upload are retried, so they can never race the load.
	wire         cfg_access   = cfg_hit_o && (cfg_rd_i || cfg_wr_i);
	wire         cfg_write_ok = idle && cfg_wr_i && cfg_hit_o && subsys_id_write_enable_i;
	logic [31:0] merged_word;

	// Each byte lane takes new data only where its enable is set.
	genvar lane;
	generate
		for (lane = 0; lane < 4; lane++) begin : g_lane
			assign merged_word[8*lane +: 8] = cfg_be_i[lane] ? cfg_wdata_i[8*lane +: 8] :
				word_reg[8*lane +: 8];
		end
	endgenerate

	// Read bytes gather in a shadow; it lands only after a clean stop.
	always_ff @(posedge mclk_i) begin
		if (rst_i) begin
			shadow_reg <= SSID_RESET_VALUE;
			word_reg <= SSID_RESET_VALUE;
			ok_reg <= 1'b0;
		end else begin
			if (state_reg == SSID_ST_READ && bus.done)
				shadow_reg <= {shadow_reg[23:0], bus.rdata};
			if (state_reg == SSID_ST_STOP && bus.done) begin
				word_reg <= abort_reg ? SSID_RESET_VALUE : shadow_reg;
				ok_reg <= !abort_reg;
			end else if (cfg_write_ok) begin
				word_reg <= merged_word;
			end
		end
	end

	// ****************************************
	// Config side
	// ****************************************
	// The word is decoded at one offset only; other offsets are not ours.
	// Any access to it while the upload runs is answered with a retry.
	// Config side decode, retry and read data.
	assign cfg_hit_o   = (cfg_addr_i == SSID_CFG_OFFSET);
	assign cfg_retry_o = cfg_access && !idle;
	assign cfg_rdata_o = word_reg;
	// Once released, software runs its own programming writes on the pins.
	assign i2c_owned_o = !idle;
	assign upload_ok_o = ok_reg;
endmodule
`default_nettype wire

// ===== ssid_pkg.sv
// Package for the subsystem identifier loader: offsets, control bytes, timing.
// Assumes a 25 MHz PCI clock and an external I2C pin pad with open-drain drive.
package ssid_pkg;
	localparam logic [7:0]  SSID_CFG_OFFSET   = 8'h20;
	localparam logic [31:0] SSID_RESET_VALUE  = 32'h00000000;
	localparam logic [6:0]  SSID_SLAVE_ADDR   = 7'b1010000;
	localparam logic [7:0]  SSID_CTRL_WRITE   = {SSID_SLAVE_ADDR, 1'b0};
	localparam logic [7:0]  SSID_CTRL_READ    = {SSID_SLAVE_ADDR, 1'b1};
	localparam logic [7:0]  SSID_FIRST_ADDR   = 8'hfc;
	localparam int          SSID_NUM_BYTES    = 4;
	localparam int          SSID_CLK_HZ       = 25000000;
	localparam int          SSID_SCL_HZ       = 100000;
	// Quarter bit time: longest time rounds down, never below one cycle.
	localparam int          SSID_QUARTER_CYC  = (SSID_CLK_HZ / (4 * SSID_SCL_HZ)) < 1 ? 1 :
		(SSID_CLK_HZ / (4 * SSID_SCL_HZ));
	localparam int          SSID_UPLOAD_US    = 660;
	localparam int          SSID_UPLOAD_CYC   = SSID_UPLOAD_US * (SSID_CLK_HZ / 1000000);
	// Bit-level commands passed to the bit engine.
	typedef enum logic [2:0] {
		SSID_CMD_START = 3'h0,
		SSID_CMD_WRITE = 3'h1,
		SSID_CMD_READ  = 3'h2,
		SSID_CMD_STOP  = 3'h3
	} ssid_cmd_t;
endpackage

// ===== ssid_bit_if.sv
// Interface joining the upload sequencer to the I2C byte engine.
// Assumes both ends run on the same clock.
`timescale 1ns/1ps
`default_nettype none
interface ssid_bit_if;
	import ssid_pkg::*;
	logic      req;
	ssid_cmd_t cmd;
	logic [7:0] wdata;
	logic      master_ack;
	logic      done;
	logic [7:0] rdata;
	logic      slave_ack;
	modport seq (output req, output cmd, output wdata, output master_ack,
		input done, input rdata, input slave_ack);
	modport eng (input req, input cmd, input wdata, input master_ack,
		output done, output rdata, output slave_ack);
endinterface
`default_nettype wire

// ===== ssid_i2c_engine.sv
// I2C byte engine: START, STOP, byte write with ack sample, byte read with ack drive.
// Assumes open-drain pins; an enable high pulls the line low.
`timescale 1ns/1ps
`default_nettype none
module ssid_i2c_engine #(
	parameter int QUARTER = ssid_pkg::SSID_QUARTER_CYC
) (
	// Clock and reset.
	input  wire logic mclk_i,
	input  wire logic rst_i,
	// Command side.
	ssid_bit_if.eng   bus,
	// Pins.
	input  wire logic scl_i,
	output logic      scl_o,
	output logic      scl_oe_o,
	input  wire logic sda_i,
	output logic      sda_o,
	output logic      sda_oe_o
);
	import ssid_pkg::*;

	logic [15:0] tick_reg;
	logic [1:0]  phase_reg;
	logic [3:0]  bit_reg;
	logic        busy_reg;
	logic        scl_low_reg;
	logic        sda_low_reg;
	logic [8:0]  shift_reg;
	logic        done_reg;
	logic        sda_bit_reg;
	ssid_cmd_t   cmd_reg;

	// Each bit lasts four quarter periods; bit_reg counts nine bits per byte.
	wire quarter_end = (tick_reg == 16'(QUARTER - 1));
	wire is_byte     = (cmd_reg == SSID_CMD_WRITE) || (cmd_reg == SSID_CMD_READ);
	wire last_bit    = !is_byte || (bit_reg == 4'h8);

	assign scl_o     = 1'b0;
	assign sda_o     = 1'b0;
	assign scl_oe_o  = scl_low_reg;
	assign sda_oe_o  = sda_low_reg;
	assign bus.done  = done_reg;
	assign bus.rdata = shift_reg[8:1];
	assign bus.slave_ack = !shift_reg[0];

	// Line levels wanted for each quarter of the current step.
	logic sda_want;
	logic scl_want;
	always_comb begin
		scl_want = (phase_reg == 2'h1) || (phase_reg == 2'h2);
		case (cmd_reg)
			SSID_CMD_START: sda_want = (phase_reg == 2'h0) || (phase_reg == 2'h1);
			SSID_CMD_STOP:  sda_want = (phase_reg == 2'h2) || (phase_reg == 2'h3);
			SSID_CMD_READ:  sda_want = (bit_reg == 4'h8) ? !bus.master_ack : 1'b1;
			default:        sda_want = sda_bit_reg; // Moves only while the clock is low.
		endcase
	end

	// Step sequencer.
	always_ff @(posedge mclk_i) begin
		done_reg <= 1'b0;
		if (rst_i) begin
			tick_reg <= 16'h0000;
			phase_reg <= 2'h0;
			bit_reg <= 4'h0;
			busy_reg <= 1'b0;
			scl_low_reg <= 1'b0;
			sda_low_reg <= 1'b0;
			shift_reg <= 9'h1ff;
			sda_bit_reg <= 1'b1;
			cmd_reg <= SSID_CMD_STOP;
		end else if (!busy_reg) begin
			if (bus.req) begin
				busy_reg <= 1'b1;
				cmd_reg <= bus.cmd;
				shift_reg <= {bus.wdata, 1'b1};
				sda_bit_reg <= bus.wdata[7];
				bit_reg <= 4'h0;
				phase_reg <= 2'h0;
				tick_reg <= 16'h0000;
			end
		end else begin
			scl_low_reg <= !scl_want && (cmd_reg != SSID_CMD_STOP || phase_reg == 2'h0);
			sda_low_reg <= !sda_want;
			tick_reg <= quarter_end ? 16'h0000 : tick_reg + 16'h0001;
			if (quarter_end) begin
				phase_reg <= phase_reg + 2'h1;
				// Sample data at the end of the high clock phase, just before the clock falls.
				if (phase_reg == 2'h2 && is_byte && (scl_i || !scl_want))
					shift_reg <= {shift_reg[7:0], sda_i};
				if (phase_reg == 2'h3) begin
					// The next bit goes out only after the clock has fallen, never with it.
					sda_bit_reg <= shift_reg[8];
					bit_reg <= bit_reg + 4'h1;
					if (last_bit) begin
						busy_reg <= 1'b0;
						done_reg <= 1'b1;
					end
				end
			end
		end
	end
endmodule
`default_nettype wire

// ===== ssid_loader_properties.sv
// Port assertions for the identifier loader.
// Assumes binding onto ssid_loader with one clock and a synchronous reset.
`timescale 1ns/1ps
`default_nettype none
module ssid_loader_properties (
	// Watched ports.
	input wire logic        mclk_i,
	input wire logic        rst_i,
	input wire logic        cfg_rd_i,
	input wire logic        cfg_wr_i,
	input wire logic [7:0]  cfg_addr_i,
	input wire logic [31:0] cfg_wdata_i,
	input wire logic [3:0]  cfg_be_i,
	input wire logic [31:0] cfg_rdata_o,
	input wire logic        cfg_hit_o,
	input wire logic        cfg_retry_o,
	input wire logic        subsys_id_write_enable_i,
	input wire logic        scl_oe_o,
	input wire logic        sda_oe_o,
	input wire logic        i2c_owned_o,
	input wire logic        upload_ok_o
);
	import ssid_pkg::*;
	// ****
	// Assertions, all on the one clock and idle in reset.
	// ****
	default clocking cb @(posedge mclk_i); endclocking
	default disable iff (rst_i);
	a_hit_decode: assert property (cfg_hit_o == (cfg_addr_i == SSID_CFG_OFFSET))
		else $error("hit decode wrong");
	a_seize_bus: assert property ($fell(rst_i) |-> i2c_owned_o)
		else $error("bus not seized");
	a_retry_pending: assert property (i2c_owned_o && cfg_hit_o && (cfg_rd_i || cfg_wr_i) |-> cfg_retry_o)
		else $error("no retry");
	a_retry_ends: assert property (!i2c_owned_o |-> !cfg_retry_o)
		else $error("late retry");
	a_abort_zero: assert property ($fell(i2c_owned_o) && !upload_ok_o |-> cfg_rdata_o == SSID_RESET_VALUE)
		else $error("abort word not zero");
	a_write_ignored: assert property (cfg_wr_i && cfg_hit_o && !subsys_id_write_enable_i && !i2c_owned_o |=> $stable(cfg_rdata_o))
		else $error("locked write took");
	a_write_taken: assert property (cfg_wr_i && cfg_hit_o && subsys_id_write_enable_i && !i2c_owned_o && cfg_be_i == 4'hf
		|=> cfg_rdata_o == $past(cfg_wdata_i))
		else $error("enabled write lost");
	a_bus_released: assert property (!i2c_owned_o |-> !scl_oe_o && !sda_oe_o)
		else $error("bus held");
endmodule
bind ssid_loader ssid_loader_properties u_ssid_loader_properties (.*);
`default_nettype wire

// ===== ssid_eeprom_model.sv
// Serial memory model answering at the loader's slave address.
// Assumes open-drain wires resolved by the bench, high when released.
`timescale 1ns/1ps
`default_nettype none
module ssid_eeprom_model (
	// Bus wires and presence control.
	input  wire logic scl_i,
	input  wire logic sda_i,
	input  wire logic absent_i,
	output logic      sda_oe_o
);
	// ****
	// Byte framing and acknowledge.
	// ****
	logic [7:0] mem [256];
	logic [7:0] sh, ptr;
	logic       act = 1'b0, rd, dat, first;
	int         cnt;
	// Identifier bytes held at the top four addresses.
	initial begin
		sda_oe_o = 1'b0;
		mem[8'hfc] = 8'h5a;
		mem[8'hfd] = 8'h3c;
		mem[8'hfe] = 8'h96;
		mem[8'hff] = 8'he1;
	end
	// A start restarts the framing; a stop ends the transfer.
	always @(negedge sda_i) if (scl_i) begin
		{act, rd, dat, first, cnt} = {4'b1001, 32'h0};
	end
	always @(posedge sda_i) if (scl_i) act = 1'b0;
	// Bits are taken on the rising clock; a master nack ends a read.
	always @(posedge scl_i) if (act) begin
		if (cnt < 8) sh = {sh[6:0], sda_i};
		else if (cnt == 8 && dat) {act, ptr} = {!sda_i, ptr + 8'h01};
		cnt = cnt + 1;
	end
	// Data and acknowledge change only while the clock is low.
	always @(negedge scl_i) if (act) begin
		if (cnt == 9) {cnt, dat} = {32'h0, rd};
		if (cnt == 8 && !dat && first) {first, rd, act} = {1'b0, sh[0], sh[7:1] == 7'b1010000 && !absent_i};
		else if (cnt == 8 && !dat) ptr = sh;
		// A missing memory answers every control byte with a nack.
		sda_oe_o = (cnt == 8 && !dat) ? act : (dat && cnt < 8 && !mem[ptr][7 - cnt]);
	end
endmodule
`default_nettype wire

// ===== ssid_loader_tb_top.sv
// Testbench for the identifier loader with a serial memory on its bus.
// Assumes a short QUARTER so each upload takes a few hundred cycles.
`timescale 1ns/1ps
`default_nettype none
module ssid_loader_tb_top;
	import ssid_pkg::*;
	// ****
	// Stimulus, wires, instances and scenarios.
	// ****
	localparam logic [31:0] EXP_WORD = 32'h5a3c96e1;
	logic        mclk_i = 1'b0, rst_i = 1'b1, cfg_rd_i = 1'b0, cfg_wr_i = 1'b0, wr_en = 1'b0, absent = 1'b0;
	logic [7:0]  cfg_addr_i = 8'h00;
	logic [31:0] cfg_wdata_i = 32'h0, cfg_rdata_o, word;
	logic [3:0]  cfg_be_i = 4'h0;
	logic        cfg_hit_o, cfg_retry_o, scl_oe_o, sda_oe_o, mdl_oe, i2c_owned_o, upload_ok_o, retry, hit;
	int          failures = 0, checks = 0, cycles = 0, n;
	wire         scl = (scl_oe_o !== 1'b1);
	wire         sda = (sda_oe_o !== 1'b1) && !mdl_oe;
	ssid_loader #(.QUARTER(2)) u_ssid_loader (.mclk_i(mclk_i), .rst_i(rst_i), .cfg_rd_i(cfg_rd_i),
		.cfg_wr_i(cfg_wr_i), .cfg_addr_i(cfg_addr_i), .cfg_wdata_i(cfg_wdata_i), .cfg_be_i(cfg_be_i),
		.cfg_rdata_o(cfg_rdata_o), .cfg_hit_o(cfg_hit_o), .cfg_retry_o(cfg_retry_o),
		.subsys_id_write_enable_i(wr_en), .scl_i(scl), .scl_o(), .scl_oe_o(scl_oe_o), .sda_i(sda),
		.sda_o(), .sda_oe_o(sda_oe_o), .i2c_owned_o(i2c_owned_o), .upload_ok_o(upload_ok_o));
	ssid_eeprom_model u_ssid_eeprom_model (.scl_i(scl), .sda_i(sda), .absent_i(absent), .sda_oe_o(mdl_oe));
	// Clock and hang limit.
	always #20 mclk_i = ~mclk_i;
	always @(posedge mclk_i) begin
		cycles++;
		if (cycles == 20000) begin
			failures++;
			complete_run();
		end
	end
	task automatic chk(input string name, input logic [31:0] exp, input logic [31:0] got);
		checks++;
		if (got !== exp) begin
			failures++;
			$display("FAIL %s expected %h seen %h", name, exp, got);
		end
	endtask
	task automatic reset_dut();
		rst_i <= 1'b1;
		repeat (4) @(posedge mclk_i);
		rst_i <= 1'b0;
	endtask
	// One config access; results are sampled mid-cycle while the strobe stands.
	task automatic access(input logic wr, input logic [7:0] addr, input logic [31:0] data, input logic [3:0] be);
		@(posedge mclk_i);
		cfg_rd_i <= !wr;
		cfg_wr_i <= wr;
		cfg_addr_i <= addr;
		cfg_wdata_i <= data;
		cfg_be_i <= be;
		@(negedge mclk_i);
		{word, retry, hit} = {cfg_rdata_o, cfg_retry_o, cfg_hit_o};
		@(posedge mclk_i);
		cfg_rd_i <= 1'b0;
		cfg_wr_i <= 1'b0;
	endtask
	task automatic wait_free();
		for (n = 0; n < 4000 && i2c_owned_o !== 1'b0; n++) @(negedge mclk_i);
		chk("upload end", 32'h1, {31'h0, n < 4000});
	endtask
	task automatic t_upload();
		reset_dut();
		access(1'b0, SSID_CFG_OFFSET, 32'h0, 4'hf);
		chk("retry", 32'h1, {31'h0, retry});
		chk("reset word", SSID_RESET_VALUE, word);
		wait_free();
		access(1'b0, SSID_CFG_OFFSET, 32'h0, 4'hf);
		chk("word", EXP_WORD, word);
		chk("no retry", 32'h0, {31'h0, retry});
		chk("ok", 32'h1, {31'h0, upload_ok_o});
		$display("upload test done");
	endtask
	task automatic t_bios_write();
		access(1'b1, SSID_CFG_OFFSET, 32'h12345678, 4'hf);
		access(1'b0, SSID_CFG_OFFSET, 32'h0, 4'hf);
		chk("locked", EXP_WORD, word);
		wr_en <= 1'b1;
		access(1'b1, SSID_CFG_OFFSET, 32'h0bad0fee, 4'hf);
		access(1'b1, SSID_CFG_OFFSET, 32'h000000aa, 4'h1);
		access(1'b0, SSID_CFG_OFFSET, 32'h0, 4'hf);
		chk("enabled", 32'h0bad0faa, word);
		wr_en <= 1'b0;
		$display("write test done");
	endtask
	task automatic t_absent();
		absent <= 1'b1;
		reset_dut();
		access(1'b0, 8'h24, 32'h0, 4'hf);
		chk("other offset", 32'h0, {31'h0, hit | retry});
		wait_free();
		access(1'b0, SSID_CFG_OFFSET, 32'h0, 4'hf);
		chk("abort word", SSID_RESET_VALUE, word);
		chk("abort ok", 32'h0, {31'h0, upload_ok_o});
		$display("absent test done");
	endtask
	task automatic complete_run();
		$display("checks %0d failures %0d", checks, failures);
		if (failures == 0 && checks > 0)
			$display("STATUS OK");
		else
			$display("STATUS NOT OK");
		$finish;
	endtask
	initial begin
		t_upload();
		t_bios_write();
		t_absent();
		complete_run();
	end
endmodule
`default_nettype wire
